// ---- dv/cbpa_peers.sv ----
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Peer agents and host on the wired lines
module cbpa_peers (
    // Own agent drives
    input  wire logic [2:0] i_pos,
    input  wire logic       i_req_n,
    input  wire logic       i_req_oe_n,
    input  wire logic       i_dma_oe_n,
    input  wire logic       i_core_oe_n,
    // Wired lines, pulled up
    output logic [7:0]      o_bus_request_n,
    output logic            o_dma_precedence_n,
    output logic            o_core_precedence_n,
    output logic            o_host_request_n
);
    logic [7:0] req;
    logic [7:0] dma;
    logic [7:0] core;
    logic [7:0] eff;
    logic       host;
    logic       core_any;
    logic       own_low;

    initial begin
        req = 8'h00;
        dma = 8'h00;
        core = 8'h00;
        host = 1'b0;
    end

    // Job control from the bench
    task automatic set_peer(input int k, input logic r, d, c);
        req[k] = r;
        dma[k] = d & ~c;
        core[k] = c;
    endtask

    task automatic set_host(input logic h);
        host = h;
    endtask

    // Withdrawal is level based, so requests return on release
    always_comb begin
        core_any = (|core) | ~i_core_oe_n;
        o_core_precedence_n = ~core_any;
        o_dma_precedence_n = ~(|dma & ~core_any) & i_dma_oe_n;
        eff = req & ~(~dma & ~core & {8{~o_dma_precedence_n | core_any}});
        eff = eff & ~(dma & {8{core_any}});
        own_low = ~i_req_oe_n & ~i_req_n;
        o_bus_request_n = ~eff & ~({7'h00, own_low} << i_pos);
        o_host_request_n = ~host;
    end
endmodule
`default_nettype wire

// ---- dv/cluster_bus_priority_arbiter_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module cluster_bus_priority_arbiter_test;
    import cbpa_pkg::*;
    localparam logic [2:0] POS = 3'h2;
    logic       clk_sys, reset_n, core_req, dma_req, dma_high, xact_last;
    logic [7:0] bus_n;
    logic       dma_n, core_n, host_n, req_n, req_oe_n, dma_oe_n, core_oe_n;
    logic       ind_n, host_owns;
    logic [2:0] owner_pos, own_x, hi, lo;
    int         errors, checks, seed;

    cbpa_arbiter dut_u (.i_clk_sys(clk_sys), .i_reset_n(reset_n),
        .i_cluster_position(POS), .i_bus_request_n(bus_n),
        .i_dma_precedence_n(dma_n), .i_core_precedence_n(core_n),
        .i_host_request_n(host_n), .i_core_req(core_req),
        .i_dma_req(dma_req), .i_dma_high(dma_high), .i_xact_last(xact_last),
        .o_bus_request_n(req_n), .o_bus_request_oe_n(req_oe_n),
        .o_dma_precedence_oe_n(dma_oe_n), .o_core_precedence_oe_n(core_oe_n),
        .o_owner_indicator_n(ind_n), .o_owner_pos(owner_pos),
        .o_host_owns(host_owns));

    cbpa_peers peers_u (.i_pos(POS), .i_req_n(req_n), .i_req_oe_n(req_oe_n),
        .i_dma_oe_n(dma_oe_n), .i_core_oe_n(core_oe_n),
        .o_bus_request_n(bus_n), .o_dma_precedence_n(dma_n),
        .o_core_precedence_n(core_n), .o_host_request_n(host_n));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // ========================================
    // Helpers
    task automatic step(input int n = 1);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask

    task automatic check(input logic [7:0] seen, exp, input string what);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic await(input int sel, input logic [2:0] exp);
        logic [2:0] v;
        for (int n = 0; n < 64; n++) begin
            v = (sel == 0) ? owner_pos : (sel == 1) ? {2'h0, ind_n} :
                (sel == 2) ? {2'h0, req_oe_n} : {2'h0, host_owns};
            if (v === exp) break;
            step();
        end
        check({5'h00, v}, {5'h00, exp}, $sformatf("wait%0d", sel));
        if (v !== exp) results();
    endtask

    task automatic xact_end(input logic keep);
        xact_last = 1'b1;
        if (!keep) begin
            dma_req = 1'b0;
            core_req = 1'b0;
            dma_high = 1'b0;
        end
        step();
        xact_last = 1'b0;
        step();
    endtask

    function automatic logic [2:0] next_owner(input logic [2:0] cur,
                                              input logic [7:0] rv);
        logic [2:0] p;
        next_owner = cur;
        for (int i = 8; i >= 1; i--) begin
            p = cur + 3'(i);
            if (rv[p]) next_owner = p;
        end
    endfunction

    task automatic results();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ========================================
    // Main sequence
    initial begin
        seed = 32'hce13;
        errors = 0;
        checks = 0;
        {reset_n, core_req, dma_req, dma_high, xact_last} = 5'h00;
        repeat (8) @(posedge clk_sys);
        #5 reset_n = 1'b1;
        step(3);
        check({host_owns, ind_n, req_oe_n, dma_oe_n, core_oe_n, owner_pos},
              8'h78, "reset");
        dma_req = 1'b1;
        step();
        check({6'h00, req_n, req_oe_n}, 8'h00, "req_drive");
        own_x = next_owner(3'h0, 8'h04);
        await(0, own_x);
        await(1, 3'h0);
        xact_end(0);
        check({4'h0, req_n, req_oe_n, dma_oe_n, ind_n}, 8'h0f,
              "release");
        for (int r = 0; r < 4; r++) begin
            dma_req = 1'b1;
            await(1, 3'h0);
            hi = 3'(3 + ($unsigned($random(seed)) % 4));
            lo = 3'($random(seed) & 1);
            peers_u.set_peer(lo, 1, 0, 0);
            peers_u.set_peer(hi, 1, 1, 0);
            peers_u.set_peer(7, 1, 1, 0);
            step(1 + ($unsigned($random(seed)) % 4));
            check({7'h00, ind_n}, 8'h00, "hold");
            xact_end(1);
            check({7'h00, ind_n}, 8'h01, "drain");
            await(0, next_owner(POS, (8'h01 << hi) | 8'h80));
            peers_u.set_peer(hi, 0, 0, 0);
            step(3);
            check({7'h00, req_oe_n}, 8'h01, "withdrawn");
            await(0, 3'h7);
            peers_u.set_peer(7, 0, 0, 0);
            await(2, 3'h0);
            own_x = next_owner(3'h7, (8'h01 << lo) | 8'h04);
            await(0, own_x);
            peers_u.set_peer(lo, 0, 0, 0);
            await(0, POS);
            await(1, 3'h0);
            xact_end(0);
        end
        peers_u.set_peer(4, 1, 0, 0);
        step();
        dma_req = 1'b1;
        step(2);
        check({6'h00, req_oe_n, ind_n}, 8'h01, "queued");
        peers_u.set_peer(6, 1, 1, 0);
        step(2);
        check({7'h00, req_oe_n}, 8'h01, "plain_yield");
        await(0, 3'h6);
        peers_u.set_peer(6, 0, 0, 0);
        peers_u.set_peer(4, 0, 0, 0);
        await(1, 3'h0);
        xact_end(0);
        dma_req = 1'b1;
        dma_high = 1'b1;
        step();
        check({6'h00, req_oe_n, dma_oe_n}, 8'h00, "dma_drive");
        await(1, 3'h0);
        peers_u.set_peer(3, 1, 0, 1);
        step(2);
        check({7'h00, ind_n}, 8'h00, "hold_core");
        xact_end(1);
        step(4);
        check({6'h00, req_oe_n, dma_oe_n}, 8'h03, "yield");
        peers_u.set_peer(3, 0, 0, 0);
        await(2, 3'h0);
        await(1, 3'h0);
        xact_end(0);
        check({6'h00, req_oe_n, dma_oe_n}, 8'h03, "dma_done");
        dma_req = 1'b1;
        dma_high = 1'b1;
        step();
        peers_u.set_peer(3, 1, 0, 1);
        step(3);
        check({6'h00, req_oe_n, dma_oe_n}, 8'h03, "queue_yield");
        peers_u.set_peer(3, 0, 0, 0);
        await(1, 3'h0);
        xact_end(0);
        {core_req, dma_req, dma_high} = 3'h7;
        step();
        check({5'h00, req_oe_n, dma_oe_n, core_oe_n}, 8'h02, "core");
        await(1, 3'h0);
        xact_end(0);
        check({5'h00, req_oe_n, dma_oe_n, core_oe_n}, 8'h07, "idle");
        peers_u.set_host(1);
        await(3, 3'h1);
        dma_req = 1'b1;
        step(4);
        check({7'h00, ind_n}, 8'h01, "host_holds");
        peers_u.set_host(0);
        await(1, 3'h0);
        xact_end(0);
        results();
    end
endmodule
`default_nettype wire

// ---- rtl/cbpa_arbiter.sv ----
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Idle lines: ownership rotates by cluster position
// - Host request takes the bus once the current owner drops its request
// - Precedence request drives bus request plus class
// - High-priority DMA drives dma precedence line
// - Owner finishes transaction, then drops request
// - Normal DMA withdraws while dma precedence seen
// - Highest rotating rank wins among priority
// - Priority DMA done: drop request and line
// - Withdrawn normal requests return after release
// - Rotation resumes upward from pre-empting agent
// - Pre-empted DMA stays pending, resumes later
// - Owner indicator shows local bus ownership
// - Position zero owns after reset
// - Host, core, dma, plain precedence order
// - Dma line only when core line idle
// - Dma requester yields to any core line
module cbpa_arbiter (
    // Clock and reset
    input  wire logic                               i_clk_sys,
    input  wire logic                               i_reset_n,
    // Static position
    input  wire logic [cbpa_pkg::CBPA_POS_W-1:0]    i_cluster_position,
    // Shared lines, sampled (active low)
    input  wire logic [cbpa_pkg::CBPA_NUM_AGENTS-1:0] i_bus_request_n,
    input  wire logic                               i_dma_precedence_n,
    input  wire logic                               i_core_precedence_n,
    input  wire logic                               i_host_request_n,
    // Local transfer requests
    input  wire logic                               i_core_req,
    input  wire logic                               i_dma_req,
    input  wire logic                               i_dma_high,
    input  wire logic                               i_xact_last,
    // Open-drain line drives (oe low = drive low)
    output logic                                    o_bus_request_n,
    output logic                                    o_bus_request_oe_n,
    output logic                                    o_dma_precedence_oe_n,
    output logic                                    o_core_precedence_oe_n,
    // Ownership status
    output logic                                    o_owner_indicator_n,
    output logic [cbpa_pkg::CBPA_POS_W-1:0]         o_owner_pos,
    output logic                                    o_host_owns
);
    import cbpa_pkg::*;

    // ========================================
    // Reset synchroniser
    logic rst_s1_q;
    logic rst_n_q;
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // ========================================
    // Line decode
    logic [CBPA_NUM_AGENTS-1:0] req_v;
    logic                       core_act;
    logic                       dma_act;
    logic                       host_act;
    assign req_v    = ~i_bus_request_n;
    assign core_act = ~i_core_precedence_n;
    assign dma_act  = ~i_dma_precedence_n;
    assign host_act = ~i_host_request_n;

    // ========================================
    // Shared owner tracking, same in every agent
    logic [CBPA_POS_W-1:0] owner_q;
    logic [CBPA_POS_W-1:0] owner_d;
    logic                  host_q;
    logic                  host_d;
    logic                  pick_any;
    logic [CBPA_POS_W-1:0] pick_pos;
    logic [CBPA_POS_W-1:0] base;

    // Next from owner, or owner itself while it holds
    assign base = req_v[owner_q] ? owner_q : owner_q + 3'h1;

    cbpa_pick u_pick (
        .i_req (req_v),
        .i_base(base),
        .o_any (pick_any),
        .o_pos (pick_pos)
    );

    always_comb begin
        owner_d = owner_q;
        host_d  = host_q;
        if (host_act) begin
            host_d = !req_v[owner_q] || host_q;
        end else begin
            host_d = 1'b0;
        end
        // Owner keeps bus until its request is withdrawn
        if (!host_d && !req_v[owner_q] && pick_any) begin
            owner_d = pick_pos;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            owner_q <= CBPA_RESET_OWNER;
            host_q  <= 1'b0;
        end else begin
            owner_q <= owner_d;
            host_q  <= host_d;
        end
    end

    // ========================================
    // Local request state machine
    cbpa_state_t st_q;
    cbpa_state_t st_d;
    cbpa_class_t cls_q;
    cbpa_class_t cls_d;
    logic        want_core;
    logic        want_dhi;
    logic        want_any;
    logic        self_own;
    logic        higher_seen;
    logic        yield;

    assign want_core = i_core_req;
    assign want_dhi  = i_dma_req && i_dma_high && !i_core_req;
    assign want_any  = i_core_req || i_dma_req;
    assign self_own  = !host_q && owner_q == i_cluster_position;

    // Competing precedence above local class
    always_comb begin
        case (cls_q)
            CBPA_CLS_CORE:  higher_seen = host_act;
            CBPA_CLS_DMA:   higher_seen = host_act || core_act;
            CBPA_CLS_PLAIN: higher_seen = host_act || core_act || dma_act;
            default:        higher_seen = host_act;
        endcase
    end

    // Only lower classes withdraw while not owning
    always_comb begin
        case (cls_q)
            CBPA_CLS_DMA:   yield = core_act;
            CBPA_CLS_PLAIN: yield = core_act || dma_act;
            default:        yield = 1'b0;
        endcase
    end

    always_comb begin
        st_d  = st_q;
        cls_d = cls_q;
        case (st_q)
            CBPA_ST_IDLE: begin
                if (want_core) begin
                    cls_d = CBPA_CLS_CORE;
                    st_d  = CBPA_ST_REQ;
                end else if (want_dhi && !core_act) begin
                    cls_d = CBPA_CLS_DMA;
                    st_d  = CBPA_ST_REQ;
                end else if (i_dma_req && !core_act && !dma_act) begin
                    cls_d = CBPA_CLS_PLAIN;
                    st_d  = CBPA_ST_REQ;
                end
            end
            CBPA_ST_REQ: begin
                if (!want_any) begin
                    st_d = CBPA_ST_IDLE;
                end else if (yield) begin
                    st_d = CBPA_ST_IDLE;
                end else if (self_own) begin
                    st_d = CBPA_ST_OWN;
                end
            end
            CBPA_ST_OWN: begin
                if (!self_own) begin
                    st_d = CBPA_ST_IDLE;
                end else if (higher_seen || !want_any) begin
                    st_d = CBPA_ST_DRAIN;
                end
            end
            CBPA_ST_DRAIN: begin
                // Current transaction completes first
                if (i_xact_last || !want_any) begin
                    st_d = CBPA_ST_IDLE;
                end
            end
            default: begin
                st_d = CBPA_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q  <= CBPA_ST_IDLE;
            cls_q <= CBPA_CLS_PLAIN;
        end else begin
            st_q  <= st_d;
            cls_q <= cls_d;
        end
    end

    // ========================================
    // Registered line drives
    logic drv_req;
    logic drv_dpa;
    logic drv_cpa;
    assign drv_req = st_d != CBPA_ST_IDLE;
    assign drv_cpa = drv_req && cls_d == CBPA_CLS_CORE;
    assign drv_dpa = drv_req && cls_d == CBPA_CLS_DMA;

    always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            o_bus_request_n        <= 1'b1;
            o_bus_request_oe_n     <= 1'b1;
            o_dma_precedence_oe_n  <= 1'b1;
            o_core_precedence_oe_n <= 1'b1;
            o_owner_indicator_n    <= 1'b1;
            o_owner_pos            <= CBPA_RESET_OWNER;
            o_host_owns            <= 1'b0;
        end else begin
            o_bus_request_n        <= !drv_req;
            o_bus_request_oe_n     <= !drv_req;
            o_dma_precedence_oe_n  <= !drv_dpa;
            o_core_precedence_oe_n <= !drv_cpa;
            o_owner_indicator_n    <= !(st_d == CBPA_ST_OWN
                                     || st_d == CBPA_ST_DRAIN);
            o_owner_pos            <= owner_d;
            o_host_owns            <= host_d;
        end
    end

    // ========================================
    // Checks
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!rst_n_q);

    dpa_core_excl_a: assert property (
        !o_core_precedence_oe_n |-> o_dma_precedence_oe_n)
        else $error("dma and core precedence driven together");
    dpa_needs_br_a: assert property (
        !o_dma_precedence_oe_n |-> !o_bus_request_oe_n)
        else $error("dma precedence without bus request");
    owner_has_br_a: assert property (
        !o_owner_indicator_n |-> !o_bus_request_oe_n)
        else $error("owner indicator without bus request");
    plain_yield_a: assert property (
        (st_q == CBPA_ST_REQ && cls_q == CBPA_CLS_PLAIN && dma_act)
        |=> o_bus_request_oe_n)
        else $error("plain request kept under dma precedence");
    dma_yield_a: assert property (
        (st_q == CBPA_ST_REQ && cls_q == CBPA_CLS_DMA && core_act)
        |=> o_bus_request_oe_n && o_dma_precedence_oe_n)
        else $error("dma requester ignored core precedence");
    drain_hold_a: assert property (
        (st_q == CBPA_ST_DRAIN && !i_xact_last && want_any)
        |=> !o_bus_request_oe_n)
        else $error("request dropped mid transaction");
    owner_hold_a: assert property (
        (req_v[owner_q] && !host_act) |=> owner_q == $past(owner_q))
        else $error("ownership moved while owner requests");
    own_flag_a: assert property (
        (st_q == CBPA_ST_REQ && self_own && want_any && !yield)
        |=> !o_owner_indicator_n)
        else $error("owner indicator not raised");

    dma_wait_a: assert property (
        (st_q == CBPA_ST_IDLE && core_act) |=> o_dma_precedence_oe_n)
        else $error("dma precedence raised under core precedence");
    plain_wait_a: assert property (
        (st_q == CBPA_ST_IDLE && (core_act || dma_act) && !i_core_req
         && !i_dma_high) |=> o_bus_request_oe_n)
        else $error("plain request raised under precedence");
    core_first_a: assert property (
        (st_q == CBPA_ST_IDLE && i_core_req)
        |=> !o_core_precedence_oe_n && !o_bus_request_oe_n)
        else $error("core request not driven with precedence");
    lines_release_a: assert property (
        (st_q == CBPA_ST_DRAIN && i_xact_last) |=> o_bus_request_oe_n
        && o_dma_precedence_oe_n && o_core_precedence_oe_n)
        else $error("lines kept after last transaction");
    host_excl_a: assert property (
        o_host_owns |-> o_owner_indicator_n)
        else $error("owner indicator while host holds bus");
    own_pos_a: assert property (
        !o_owner_indicator_n
        |-> o_owner_pos == i_cluster_position)
        else $error("owner indicator with foreign owner position");

    cov_pre_c:   cover property (dma_act && st_q == CBPA_ST_DRAIN);
    cov_core_c:  cover property (!o_core_precedence_oe_n
                                 && !o_owner_indicator_n);
    cov_host_c:  cover property (host_q);
    cov_yield_c: cover property (st_q == CBPA_ST_REQ && yield);
    cov_wrap_c:  cover property (owner_q == CBPA_MAX_POS
                                 ##[1:20] owner_q == CBPA_RESET_OWNER);
endmodule
`default_nettype wire

// ---- rtl/cbpa_pick.sv ----
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Rotating next-owner selector
module cbpa_pick (
    // Request vector and rotation base
    input  wire logic [cbpa_pkg::CBPA_NUM_AGENTS-1:0] i_req,
    input  wire logic [cbpa_pkg::CBPA_POS_W-1:0]      i_base,
    // Result
    output logic                                      o_any,
    output logic [cbpa_pkg::CBPA_POS_W-1:0]           o_pos
);
    import cbpa_pkg::*;

    always_comb begin
        logic [CBPA_POS_W-1:0] idx;
        logic                  found;
        idx   = '0;
        found = 1'b0;
        o_pos = i_base;
        // Search upward from base, wrapping to zero
        for (int k = 0; k < CBPA_NUM_AGENTS; k++) begin
            idx = i_base + CBPA_POS_W'(k);
            if (!found && i_req[idx]) begin
                found = 1'b1;
                o_pos = idx;
            end
        end
        o_any = found;
    end
endmodule
`default_nettype wire

// ---- rtl/cbpa_pkg.sv ----
package cbpa_pkg;
    // ========================================
    // Cluster geometry
    localparam int unsigned CBPA_NUM_AGENTS = 8;
    localparam int unsigned CBPA_POS_W      = 3;
    localparam logic [2:0]  CBPA_RESET_OWNER = 3'h0;
    localparam logic [2:0]  CBPA_MAX_POS     = 3'h7;

    // ========================================
    // Request classes, highest first
    typedef enum logic [3:0] {
        CBPA_CLS_HOST  = 4'h8,
        CBPA_CLS_CORE  = 4'h4,
        CBPA_CLS_DMA   = 4'h2,
        CBPA_CLS_PLAIN = 4'h1
    } cbpa_class_t;

    // ========================================
    // Local transaction states
    typedef enum logic [3:0] {
        CBPA_ST_IDLE  = 4'h1,
        CBPA_ST_REQ   = 4'h2,
        CBPA_ST_OWN   = 4'h4,
        CBPA_ST_DRAIN = 4'h8
    } cbpa_state_t;
endpackage
